// ==== rtl/add_and_bitclear_exec.sv ====
`timescale 1ns/1ps
module add_and_bitclear_exec
  import exec_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [INSN_W-1:0] insn,
  input wire logic insn_valid,
  input wire logic [DATA_W-1:0] port_pins,
  output logic [DATA_W-1:0] acc,
  output logic [DATA_W-1:0] port_latch,
  output flags_t flags,
  output logic busy,
  output logic [ADDR_W-1:0] dbg_addr,
  output logic [DATA_W-1:0] dbg_data
);
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] acc_d;
  flags_t flags_q;
  flags_t flags_d;
  logic [DATA_W-1:0] file_q [2**ADDR_W];
  op_t op;
  logic dest_file;
  wire logic [DATA_W-1:0] lit;
  wire logic [ADDR_W-1:0] faddr;
  wire logic [BIT_W-1:0] bsel;
  wire logic [DATA_W-1:0] file_rd;
  wire logic [DATA_W-1:0] operand;
  wire logic [DATA_W:0] sum;
  wire logic [NIB_LSB:0] nib_sum;
  wire logic [DATA_W-1:0] and_res;
  wire logic [DATA_W-1:0] clr_res;
  wire logic [DATA_W-1:0] result;
  wire logic is_add;
  wire logic is_file_op;
  wire wr_ctl_t ctl;

  insn_decode u_dec
  (
    .insn(insn),
    .insn_valid(insn_valid),
    .op(op),
    .dest_file(dest_file)
  );

  assign lit = insn[DATA_W-1:0];
  assign faddr = insn[ADDR_W-1:0];
  assign bsel = insn[BIT_LSB +: BIT_W];
  // port reads see the pins so rewrites follow external drive
  assign file_rd = (faddr == PORT_ADDR) ? port_pins : file_q[faddr];
  assign is_file_op = (op == OP_ADD_FILE) || (op == OP_AND_FILE);
  assign operand = is_file_op ? file_rd : lit;
  assign is_add = (op == OP_ADD_LIT) || (op == OP_ADD_FILE);
  assign sum = {1'b0, acc_q} + {1'b0, operand};
  assign nib_sum = {1'b0, acc_q[3:0]} + {1'b0, operand[3:0]};
  assign and_res = acc_q & operand;
  assign clr_res = file_rd & ~(8'h01 << bsel);
  assign result = is_add ? sum[DATA_W-1:0] : and_res;

  assign ctl.acc_we = (op == OP_ADD_LIT) || (op == OP_AND_LIT) ||
                      (is_file_op && !dest_file);
  assign ctl.file_we = (is_file_op && dest_file) ||
                       (op == OP_CLR_BIT);
  assign ctl.flags_we = is_add || (op == OP_AND_LIT) ||
                        (op == OP_AND_FILE);
  assign ctl.zero_only = !is_add;

  always_comb
  begin
    acc_d = ctl.acc_we ? result : acc_q;
    flags_d = flags_q;
    if (ctl.flags_we)
    begin
      flags_d.zero = (result == 8'h00);
      if (!ctl.zero_only)
      begin
        flags_d.carry = sum[DATA_W];
        flags_d.half_carry_flag = nib_sum[NIB_LSB];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc_q <= ACC_RST;
      flags_q <= '0;
    end
    else
    begin
      acc_q <= acc_d;
      flags_q <= flags_d;
    end
  end

  // file array has no reset; only its writes are defined
  always_ff @(posedge mclk)
  begin
    if (!rst && ctl.file_we)
    begin
      file_q[faddr] <= (op == OP_CLR_BIT) ? clr_res : result;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dbg_addr <= '0;
      dbg_data <= FILE_RST;
      port_latch <= FILE_RST;
    end
    else
    begin
      if (ctl.file_we)
      begin
        dbg_addr <= faddr;
        dbg_data <= (op == OP_CLR_BIT) ? clr_res : result;
      end
      if (ctl.file_we && faddr == PORT_ADDR)
      begin
        port_latch <= (op == OP_CLR_BIT) ? clr_res : result;
      end
    end
  end

  assign acc = acc_q;
  assign flags = flags_q;
  assign busy = 1'b0;

  AST_ADD_LIT: assert property (@(posedge mclk) disable iff (rst)
    op == OP_ADD_LIT |=> acc == $past(acc_q + lit))
    else $error("add literal result wrong");

  AST_ADD_LIT_FLAGS: assert property (@(posedge mclk) disable iff (rst)
    op == OP_ADD_LIT |=> flags.carry == $past(sum[DATA_W]) &&
    flags.half_carry_flag == $past(nib_sum[NIB_LSB]))
    else $error("add literal carries wrong");

  AST_ADD_LIT_Z: assert property (@(posedge mclk) disable iff (rst)
    op == OP_ADD_LIT |=> flags.zero == (acc == 8'h00))
    else $error("add literal zero wrong");

  AST_AND_LIT_FLAGS: assert property (@(posedge mclk) disable iff (rst)
    op == OP_AND_LIT |=> flags.carry == $past(flags_q.carry) &&
    flags.half_carry_flag == $past(flags_q.half_carry_flag) &&
    flags.zero == (acc == 8'h00))
    else $error("and literal flags wrong");

  AST_AND_LIT_ACC: assert property (@(posedge mclk) disable iff (rst)
    op == OP_AND_LIT |=> acc == $past(acc_q & lit))
    else $error("and literal result wrong");

  AST_ADD_FILE_C: assert property (@(posedge mclk) disable iff (rst)
    op == OP_ADD_FILE |=> flags.carry == $past(sum[DATA_W]))
    else $error("add file carry wrong");

  AST_ADD_FILE_ACC: assert property (@(posedge mclk) disable iff (rst)
    op == OP_ADD_FILE && !dest_file |=> acc == $past(sum[DATA_W-1:0]))
    else $error("add file to acc wrong");

  AST_ADD_FILE_HC: assert property (@(posedge mclk) disable iff (rst)
    op == OP_ADD_FILE |=>
    flags.half_carry_flag == $past(nib_sum[NIB_LSB]) &&
    flags.zero == ($past(sum[DATA_W-1:0]) == 8'h00))
    else $error("add file half carry or zero wrong");

  AST_AND_FILE_ACC: assert property (@(posedge mclk) disable iff (rst)
    op == OP_AND_FILE && !dest_file |=> acc == $past(and_res))
    else $error("and file to acc wrong");

  AST_AND_FILE_FLAGS: assert property (@(posedge mclk) disable iff (rst)
    op == OP_AND_FILE |=> flags.carry == $past(flags_q.carry) &&
    flags.half_carry_flag == $past(flags_q.half_carry_flag) &&
    flags.zero == ($past(and_res) == 8'h00))
    else $error("and file flags wrong");

  AST_AND_FILE_WB: assert property (@(posedge mclk) disable iff (rst)
    op == OP_AND_FILE && dest_file |=>
    dbg_data == $past(and_res) && dbg_addr == $past(faddr))
    else $error("and file write back wrong");

  AST_DEST_FILE: assert property (@(posedge mclk) disable iff (rst)
    is_file_op && dest_file |=> $stable(acc))
    else $error("acc changed with file destination");

  AST_DEST_ACC: assert property (@(posedge mclk) disable iff (rst)
    is_file_op && !dest_file |=> $stable(dbg_addr) && $stable(dbg_data))
    else $error("file written with acc destination");

  AST_CLR_BIT: assert property (@(posedge mclk) disable iff (rst)
    op == OP_CLR_BIT |=> $stable(flags) && $stable(acc) &&
    dbg_data == $past(clr_res))
    else $error("bit clear wrong");

  AST_CLR_BIT_REST: assert property (@(posedge mclk) disable iff (rst)
    op == OP_CLR_BIT |=> dbg_addr == $past(faddr) &&
    ((dbg_data ^ $past(file_rd)) & ~(8'h01 << $past(bsel))) == 8'h00)
    else $error("bit clear touched other bits");

  AST_PORT_PINS: assert property (@(posedge mclk) disable iff (rst)
    op == OP_CLR_BIT && faddr == PORT_ADDR |=>
    port_latch == ($past(port_pins) & ~(8'h01 << $past(bsel))))
    else $error("port rewrite ignored pins");

  AST_PORT_LATCH: assert property (@(posedge mclk) disable iff (rst)
    ctl.file_we && faddr == PORT_ADDR |=> port_latch == dbg_data)
    else $error("port latch not written");

  AST_LATCH_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !(ctl.file_we && faddr == PORT_ADDR) |=> $stable(port_latch))
    else $error("port latch changed without write");

  AST_ONE_CYCLE: assert property (@(posedge mclk) disable iff (rst)
    op == OP_ADD_LIT ##1 op == OP_ADD_LIT |=>
    acc == $past(acc_q, 2) + $past(lit, 2) + $past(lit))
    else $error("back to back adds lost");

  AST_IDLE_HOLD: assert property (@(posedge mclk) disable iff (rst)
    op == OP_NONE |=> $stable(acc) && $stable(flags))
    else $error("state changed without instruction");
endmodule

// ==== inc/exec_pkg.sv ====
package exec_pkg;
  localparam int unsigned INSN_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned BIT_W = 3;
  // opcode patterns, upper bits of the instruction word
  localparam logic [4:0] OPC_ADD_LIT = 5'h1F; // 11 111x, top five bits
  localparam logic [5:0] OPC_AND_LIT = 6'h39; // 11 1001
  localparam logic [5:0] OPC_ADD_FILE = 6'h07; // 00 0111
  localparam logic [5:0] OPC_AND_FILE = 6'h05; // 00 0101
  localparam logic [3:0] OPC_CLR_BIT = 4'h4; // 01 00
  // field positions
  localparam int unsigned DEST_POS = 7;
  localparam int unsigned BIT_LSB = 7;
  localparam int unsigned NIB_LSB = 4;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
  localparam logic [ADDR_W-1:0] PORT_ADDR = 7'h06;

  typedef enum logic [2:0]
  {
    OP_NONE = 3'b000,
    OP_ADD_LIT = 3'b001,
    OP_AND_LIT = 3'b010,
    OP_ADD_FILE = 3'b011,
    OP_AND_FILE = 3'b100,
    OP_CLR_BIT = 3'b101
  } op_t;

  typedef struct packed
  {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } flags_t;

  typedef struct packed
  {
    logic acc_we;
    logic file_we;
    logic flags_we;
    logic zero_only;
  } wr_ctl_t;
endpackage

// ==== rtl/insn_decode.sv ====
`timescale 1ns/1ps
module insn_decode
  import exec_pkg::*;
(
  input wire logic [INSN_W-1:0] insn,
  input wire logic insn_valid,
  output op_t op,
  output logic dest_file
);
  wire logic add_lit_hit;
  wire logic and_lit_hit;
  wire logic add_file_hit;
  wire logic and_file_hit;
  wire logic clr_bit_hit;
  assign add_lit_hit = insn[13:9] == OPC_ADD_LIT;
  assign and_lit_hit = insn[13:8] == OPC_AND_LIT;
  assign add_file_hit = insn[13:8] == OPC_ADD_FILE;
  assign and_file_hit = insn[13:8] == OPC_AND_FILE;
  assign clr_bit_hit = insn[13:10] == OPC_CLR_BIT;
  assign dest_file = insn[DEST_POS];
  assign op = !insn_valid ? OP_NONE :
              add_lit_hit ? OP_ADD_LIT :
              and_lit_hit ? OP_AND_LIT :
              add_file_hit ? OP_ADD_FILE :
              and_file_hit ? OP_AND_FILE :
              clr_bit_hit ? OP_CLR_BIT : OP_NONE;
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import exec_pkg::*;
;
  typedef struct packed
  {
    logic [7:0] acc;
    flags_t fl;
    logic [7:0] lat;
    logic [6:0] da;
    logic [7:0] dd;
  } note_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] insn = 14'h0000;
  logic insn_valid = 1'b0;
  logic [7:0] port_pins = 8'h00;
  logic [7:0] acc, port_latch, dbg_data;
  logic [6:0] dbg_addr;
  flags_t flags;
  logic busy;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 32'h6154BB55;
  note_t q[$];
  note_t m, n;
  logic [7:0] m_file [128];

  add_and_bitclear_exec u_dut (.mclk(mclk), .rst(rst), .insn(insn),
    .insn_valid(insn_valid), .port_pins(port_pins), .acc(acc),
    .port_latch(port_latch), .flags(flags), .busy(busy),
    .dbg_addr(dbg_addr), .dbg_data(dbg_data));

  initial
  begin
    forever #4 mclk = ~mclk;
  end

  task automatic check(input string nm, input logic [7:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // reference model runs alongside; file reads of the port see the pins
  task automatic run(input logic [13:0] w);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] f, opd, r;
    logic lit;
    @(negedge mclk);
    insn = w;
    insn_valid = 1'b1;
    port_pins = 8'($random(seed));
    f = (w[6:0] == PORT_ADDR) ? port_pins : m_file[w[6:0]];
    lit = w[13:9] == OPC_ADD_LIT || w[13:8] == OPC_AND_LIT;
    opd = lit ? w[7:0] : f;
    s = {1'b0, m.acc} + {1'b0, opd};
    h = {1'b0, m.acc[3:0]} + {1'b0, opd[3:0]};
    if (w[13:9] == OPC_ADD_LIT || w[13:8] == OPC_ADD_FILE)
    begin
      r = s[7:0];
      m.fl = {s[8], h[4], r == 8'h00};
    end
    else if (w[13:8] == OPC_AND_LIT || w[13:8] == OPC_AND_FILE)
    begin
      r = m.acc & opd;
      m.fl.zero = r == 8'h00;
    end
    else
      r = f & ~(8'h01 << w[9:7]);
    if (lit || (w[13:12] == 2'b00 && !w[7]))
      m.acc = r;
    else
    begin
      m_file[w[6:0]] = r;
      m.da = w[6:0];
      m.dd = r;
      if (w[6:0] == PORT_ADDR)
        m.lat = r;
    end
    q.push_back(m);
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      give_verdict();
    end
    if (rst === 1'b0 && insn_valid === 1'b1)
    begin
      #1;
      n = q.pop_front();
      check("acc", acc, n.acc);
      check("flags", {5'h00, flags}, {5'h00, n.fl});
      check("port_latch", port_latch, n.lat);
      check("dbg_addr", {1'b0, dbg_addr}, {1'b0, n.da});
      check("dbg_data", dbg_data, n.dd);
      check("busy", {7'h00, busy}, 8'h00);
    end
  end

  initial
  begin
    logic [31:0] r32;
    logic [13:0] w;
    m = '0;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    check("acc_rst", acc, ACC_RST);
    // acc is zero: and-to-file clears every file location first
    for (int a = 0; a < 128; a++)
    begin
      m_file[a] = 8'h00;
      run(14'h0580 | 14'(a));
    end
    run(14'h3900);
    run(14'h3EFF);
    run(14'h3E01);
    run(14'h1186);
    run(14'h0786);
    for (int i = 0; i < 400; i++)
    begin
      r32 = $random(seed);
      w = r32[13:0];
      case (r32[18:16])
        3'd0, 3'd6: w[13:9] = OPC_ADD_LIT;
        3'd1: w[13:8] = OPC_AND_LIT;
        3'd2, 3'd7: w[13:8] = OPC_ADD_FILE;
        3'd3: w[13:8] = OPC_AND_FILE;
        default: w[13:10] = OPC_CLR_BIT;
      endcase
      run(w);
      if (r32[22:20] == 3'd0)
      begin
        @(negedge mclk);
        insn = 14'($random(seed));
        insn_valid = 1'b0;
      end
    end
    @(negedge mclk);
    insn_valid = 1'b0;
    repeat (3) @(negedge mclk);
    give_verdict();
  end
endmodule
